// *** svic_defs.vh ***
// Constants for the six-source vectored interrupt controller.
// Assumes inclusion by bare name from the controller's design files.
`ifndef SVIC_DEFS_VH
`define SVIC_DEFS_VH
`define SVIC_IDX_CTRL_FIRST   8'h0B
`define SVIC_IDX_CTRL_SECOND  8'h1E
`define SVIC_ADDR_CTRL_FIRST  12'h02C
`define SVIC_ADDR_CTRL_SECOND 12'h078
`define SVIC_ADDR_STATUS      12'h100
`define SVIC_BIT_GIE          0
`define SVIC_BIT_EN_X0        1
`define SVIC_BIT_EN_X1        2
`define SVIC_BIT_EN_C0        3
`define SVIC_BIT_RQ_X0        4
`define SVIC_BIT_RQ_X1        5
`define SVIC_BIT_RQ_C0        6
`define SVIC_BIT_EN_C1        0
`define SVIC_BIT_EN_TB        1
`define SVIC_BIT_EN_RT        2
`define SVIC_BIT_RQ_C1        4
`define SVIC_BIT_RQ_TB        5
`define SVIC_BIT_RQ_RT        6
`define SVIC_CTRL_RESET       8'h00
`define SVIC_VEC_X0           12'h004
`define SVIC_VEC_X1           12'h008
`define SVIC_VEC_C0           12'h00C
`define SVIC_VEC_C1           12'h010
`define SVIC_VEC_TB           12'h014
`define SVIC_VEC_RT           12'h018
`define SVIC_STACK_DEPTH      3'h6
`define SVIC_RESP_OKAY        2'h0
`define SVIC_RESP_SLVERR      2'h2
`endif

// *** svic_stack.v ***
// Six-level return address stack of the controller.
// Assumes push and pop come from the same clock; a push when full drops the oldest entry.
`timescale 1ns/10ps
`include "svic_defs.vh"
module svic_stack (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        push,
	input  wire [11:0] push_addr,
	input  wire        pop,
	output reg  [11:0] top_addr,
	output wire [2:0]  stack_index,
	output wire        full
);
	reg [11:0] mem_q [0:5];
	reg [2:0]  stack_index_q;
	assign stack_index = stack_index_q;
	assign full = (stack_index_q == `SVIC_STACK_DEPTH);
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stack_index_q <= 3'h0;
			top_addr      <= 12'h000;
		end else if (pop && stack_index_q != 3'h0) begin
			stack_index_q <= stack_index_q - 3'h1;
			top_addr      <= mem_q[stack_index_q - 3'h1];
		end else if (push) begin
			// A subroutine call at full depth drops the oldest entry.
			if (full) begin
				mem_q[0] <= mem_q[1];
				mem_q[1] <= mem_q[2];
				mem_q[2] <= mem_q[3];
				mem_q[3] <= mem_q[4];
				mem_q[4] <= mem_q[5];
				mem_q[5] <= push_addr;
			end else begin
				mem_q[stack_index_q] <= push_addr;
				stack_index_q        <= stack_index_q + 3'h1;
			end
		end
	end
endmodule // svic_stack

// *** svic_ctrl.v ***
// Vectored interrupt controller with two control registers behind AXI4-Lite.
// Assumes the core sequencer supplies phase pulses, returns and its program counter.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "svic_defs.vh"
// How it works
// - Falling pin edges set request bits four, five.
// - Pins vector 04H, 08H; clear flag, global enable.
// - Counter zero flag bit six; vector 0CH.
// - Counter one flag bit four; vector 10H.
// - Time base flag bit five; vector 14H.
// - Clock tick flag bit six; vector 18H.
// - Cleared global enable blocks; flags still latch.
// - Full stack withholds acknowledge until a return.
// - Acknowledge pushes only program counter, loads vector.
// - Interrupt return sets global enable; plain return not.
// - Requests are acted upon at phase pulses.
// - Fixed priority: pins, counters, base, clock.
// - First register: global and three source enables.
// - Second register: three source enables.
// - Unimplemented bits read zero: bit seven, and bit three of the second.
// - Any latched source wakes the halted core.
// - Flags stay until serviced or software clears.
// - Second register bit seven reads zero.
// - Stack holds six levels.
module svic_ctrl (
	input  wire        core_clk,
	input  wire        rst,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        ext_irq_pin_zero_n,
	input  wire        ext_irq_pin_one_n,
	input  wire        counter_zero_ovf,
	input  wire        counter_one_ovf,
	input  wire        time_base_tick,
	input  wire        rtc_tick,
	input  wire        second_phase_pulse,
	input  wire [11:0] core_pc,
	input  wire        call_push,
	input  wire        ret_plain,
	input  wire        return_from_irq_instr,
	output reg         irq_take,
	output reg  [11:0] irq_vector,
	output wire [11:0] return_addr,
	output wire [2:0]  stack_index,
	output wire        stack_full,
	output reg         wake_up
);
	reg [2:0]  x0_sync_q;
	reg [2:0]  x1_sync_q;
	reg        gie_q;
	reg [5:0]  en_q;
	reg [5:0]  rq_q;
	reg [5:0]  set_d;
	reg [5:0]  clr_d;
	reg [5:0]  pend_d;
	reg [5:0]  grant_d;
	reg [11:0] vec_d;
	reg [11:0] awaddr_q;
	reg        aw_held_q;
	reg [7:0]  wdata_q;
	reg        wstrb_q;
	reg        w_held_q;
	reg [7:0]  first_rd;
	reg [7:0]  second_rd;
	wire       take_d;
	wire       wr_go;
	wire       wr_first;
	wire       wr_second;
	integer    i;

	// Pins pass two flip-flops; the third stage serves only edge detection.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			x0_sync_q <= 3'h7;
			x1_sync_q <= 3'h7;
		end else begin
			x0_sync_q <= {x0_sync_q[1:0], ext_irq_pin_zero_n};
			x1_sync_q <= {x1_sync_q[1:0], ext_irq_pin_one_n};
		end
	end

	// Source order is priority order: index 0 is highest.
	always @* begin
		set_d[0] = x0_sync_q[2] & ~x0_sync_q[1];
		set_d[1] = x1_sync_q[2] & ~x1_sync_q[1];
		set_d[2] = counter_zero_ovf;
		set_d[3] = counter_one_ovf;
		set_d[4] = time_base_tick;
		set_d[5] = rtc_tick;
	end

	// Acknowledge only at a phase pulse, with global enable and stack room.
	always @* begin
		pend_d  = rq_q & en_q;
		grant_d = 6'h00;
		vec_d   = `SVIC_VEC_RT;
		for (i = 5; i >= 0; i = i - 1) begin
			if (pend_d[i]) begin
				grant_d = 6'h01 << i;
			end
		end
		case (grant_d)
			6'h01: vec_d = `SVIC_VEC_X0;
			6'h02: vec_d = `SVIC_VEC_X1;
			6'h04: vec_d = `SVIC_VEC_C0;
			6'h08: vec_d = `SVIC_VEC_C1;
			6'h10: vec_d = `SVIC_VEC_TB;
			default: vec_d = `SVIC_VEC_RT;
		endcase
	end
	assign take_d = second_phase_pulse & gie_q & ~stack_full & (|pend_d);

	svic_stack u_stack (
		.core_clk    (core_clk),
		.rst         (rst),
		.push        (take_d | call_push),
		.push_addr   (core_pc),
		.pop         (ret_plain | return_from_irq_instr),
		.top_addr    (return_addr),
		.stack_index (stack_index),
		.full        (stack_full)
	);

	// AXI4-Lite write: address and data are captured independently.
	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
	assign wr_go     = aw_held_q & w_held_q & ~s_axi_bvalid;
	assign wr_first  = wr_go & wstrb_q & (awaddr_q[11:2] == `SVIC_ADDR_CTRL_FIRST >> 2);
	assign wr_second = wr_go & wstrb_q & (awaddr_q[11:2] == `SVIC_ADDR_CTRL_SECOND >> 2);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			awaddr_q     <= 12'h000;
			wdata_q      <= 8'h00;
			wstrb_q      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SVIC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata[7:0];
				wstrb_q  <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q[11:2] == `SVIC_ADDR_CTRL_FIRST >> 2 ||
					awaddr_q[11:2] == `SVIC_ADDR_CTRL_SECOND >> 2 ||
					awaddr_q[11:2] == `SVIC_ADDR_STATUS >> 2) ? `SVIC_RESP_OKAY : `SVIC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software clears flags by writing zero; hardware set wins over clear.
	always @* begin
		clr_d = 6'h00;
		if (wr_first) begin
			clr_d[0] = ~wdata_q[`SVIC_BIT_RQ_X0];
			clr_d[1] = ~wdata_q[`SVIC_BIT_RQ_X1];
			clr_d[2] = ~wdata_q[`SVIC_BIT_RQ_C0];
		end
		if (wr_second) begin
			clr_d[3] = ~wdata_q[`SVIC_BIT_RQ_C1];
			clr_d[4] = ~wdata_q[`SVIC_BIT_RQ_TB];
			clr_d[5] = ~wdata_q[`SVIC_BIT_RQ_RT];
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gie_q      <= 1'b0;
			en_q       <= 6'h00;
			rq_q       <= 6'h00;
			irq_take   <= 1'b0;
			irq_vector <= 12'h000;
			wake_up    <= 1'b0;
		end else begin
			rq_q <= set_d | (rq_q & ~clr_d & ~(take_d ? grant_d : 6'h00));
			if (wr_first) begin
				en_q[0] <= wdata_q[`SVIC_BIT_EN_X0];
				en_q[1] <= wdata_q[`SVIC_BIT_EN_X1];
				en_q[2] <= wdata_q[`SVIC_BIT_EN_C0];
			end
			if (wr_second) begin
				en_q[3] <= wdata_q[`SVIC_BIT_EN_C1];
				en_q[4] <= wdata_q[`SVIC_BIT_EN_TB];
				en_q[5] <= wdata_q[`SVIC_BIT_EN_RT];
			end
			if (take_d) begin
				gie_q <= 1'b0;
			end else if (return_from_irq_instr) begin
				gie_q <= 1'b1;
			end else if (wr_first) begin
				gie_q <= wdata_q[`SVIC_BIT_GIE];
			end
			irq_take <= take_d;
			if (take_d) begin
				irq_vector <= vec_d;
			end
			wake_up <= |(rq_q | set_d);
		end
	end

	always @* begin
		first_rd  = {1'b0, rq_q[2:0], en_q[2:0], gie_q};
		second_rd = {1'b0, rq_q[5:3], 1'b0, en_q[5:3]};
	end

	// AXI4-Lite read: one cycle from address to data.
	assign s_axi_arready = ~s_axi_rvalid;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `SVIC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `SVIC_RESP_OKAY;
			case (s_axi_araddr[11:2])
				`SVIC_ADDR_CTRL_FIRST >> 2:  s_axi_rdata <= {24'h000000, first_rd};
				`SVIC_ADDR_CTRL_SECOND >> 2: s_axi_rdata <= {24'h000000, second_rd};
				`SVIC_ADDR_STATUS >> 2:      s_axi_rdata <= {24'h000000, stack_full, 1'b0, rq_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `SVIC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // svic_ctrl

// *** svic_core.sv ***
// Behavioural model of the core sequencer facing the interrupt controller.
// Assumes one clock with the controller; the bench asks for returns via ret_rq.
`timescale 1ns/10ps
module svic_core (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        irq_take,
	input  wire logic [11:0] irq_vector,
	input  wire logic [1:0]  ret_rq,
	output wire logic        second_phase_pulse,
	output logic      [11:0] core_pc,
	output wire logic        return_from_irq_instr,
	output wire logic        ret_plain
);
	logic [1:0] cnt_q;
	logic [1:0] pend_q;
	// Phase pulse every fourth cycle; returns land between pulses.
	assign second_phase_pulse = cnt_q == 2'h3;
	assign return_from_irq_instr = pend_q[0] && cnt_q == 2'h1;
	assign ret_plain = pend_q[1] && cnt_q == 2'h1;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 2'h0;
			pend_q <= 2'h0;
			core_pc <= 12'h000;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			pend_q <= (cnt_q == 2'h1 ? 2'h0 : pend_q) | ret_rq;
			core_pc <= irq_take ? irq_vector : core_pc + 12'h001;
		end
	end
endmodule // svic_core

// *** svic_ctrl_chk.sv ***
// Assertion checker for the interrupt controller.
// Assumes it is bound to svic_ctrl and sees only its ports.
`timescale 1ns/10ps
module svic_ctrl_chk (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        counter_zero_ovf,
	input wire logic        counter_one_ovf,
	input wire logic        time_base_tick,
	input wire logic        rtc_tick,
	input wire logic        second_phase_pulse,
	input wire logic        call_push,
	input wire logic        ret_plain,
	input wire logic        return_from_irq_instr,
	input wire logic        irq_take,
	input wire logic [11:0] irq_vector,
	input wire logic [2:0]  stack_index,
	input wire logic        stack_full,
	input wire logic        wake_up
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_once; irq_take |=> !irq_take; endproperty
	a_once: assert property (p_once) else $error("take repeated");
	property p_phase; irq_take |-> $past(second_phase_pulse); endproperty
	a_phase: assert property (p_phase) else $error("take off phase");
	property p_room; irq_take |-> !$past(stack_full); endproperty
	a_room: assert property (p_room) else $error("take when full");
	property p_push; irq_take && !$past(ret_plain | return_from_irq_instr | call_push)
		|-> stack_index == $past(stack_index) + 3'h1; endproperty
	a_push: assert property (p_push) else $error("no push");
	property p_vec; irq_take |-> irq_vector[1:0] == 2'h0 && irq_vector >= 12'h004 && irq_vector <= 12'h018; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_full; stack_full == (stack_index == 3'h6); endproperty
	a_full: assert property (p_full) else $error("full flag wrong");
	property p_wake; counter_zero_ovf | counter_one_ovf | time_base_tick | rtc_tick |=> wake_up; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_pop; return_from_irq_instr && stack_index != 3'h0 && !call_push
		|=> stack_index == $past(stack_index) - 3'h1; endproperty
	a_pop: assert property (p_pop) else $error("no pop");
	c_take: cover property (irq_take);
	c_full: cover property (stack_full);
	c_return_from_irq_instr: cover property (return_from_irq_instr);
endmodule // svic_ctrl_chk
bind svic_ctrl svic_ctrl_chk u_chk (.*);

// *** test_svic_ctrl.sv ***
// Self-checking bench for the interrupt controller.
// Assumes svic_ctrl, svic_core and the checker are compiled alongside.
`timescale 1ns/10ps
module test_svic_ctrl;
	logic        core_clk = 1'h0, rst = 1'h1, call_push = 1'h0, got;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0, core_pc, irq_vector, return_addr;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r, ret_rq = 2'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        second_phase_pulse, ret_plain, return_from_irq_instr, irq_take, stack_full, wake_up;
	logic [2:0]  stack_index;
	logic [5:0]  src = 6'h0;
	logic [7:0]  d, v;
	wire         ext_irq_pin_zero_n = !src[0], ext_irq_pin_one_n = !src[1], counter_zero_ovf = src[2];
	wire         counter_one_ovf = src[3], time_base_tick = src[4], rtc_tick = src[5];
	int          n_mismatch = 0, total_checks = 0;
	svic_ctrl dut (.*);
	svic_core u_core (.*);
	always #5 core_clk = ~core_clk;
	function logic [11:0] f_vec(int i);
		return 12'h004 * 12'(i + 1);
	endfunction
	function logic [7:0] f_rb(logic [11:0] a, logic [7:0] x);
		return x & (a == 12'h02C ? 8'h0F : 8'h07);
	endfunction
	task conclude;
		if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] x);
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, x};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(negedge core_clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
		end while (!tb);
		s_axi_bready <= 1'h0;
		@(posedge core_clk);
	endtask
	task rd(input logic [11:0] a, output logic [7:0] x, output logic [1:0] rr);
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(negedge core_clk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			x = s_axi_rdata[7:0];
			rr = s_axi_rresp;
			@(posedge core_clk);
			if (ta) s_axi_arvalid <= 1'h0;
		end while (!tr);
		s_axi_rready <= 1'h0;
		@(posedge core_clk);
	endtask
	task wait_take(input int lim, output logic g);
		int n;
		g = 1'h0;
		n = 0;
		while (!g && n < lim) begin
			@(negedge core_clk);
			g = irq_take;
			n++;
		end
		@(posedge core_clk);
	endtask
	task ret(input logic [1:0] k);
		ret_rq <= k;
		@(posedge core_clk);
		ret_rq <= 2'h0;
	endtask
	initial begin
		#300000;
		n_mismatch++;
		conclude;
	end
	initial begin
		void'($urandom(32'h59294746));
		repeat (10) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		rd(12'h02C, d, r); chk("first reset", 12'h0, d);
		rd(12'h078, d, r); chk("second reset", 12'h0, d);
		rd(12'h044, d, r); chk("unmapped resp", 12'h2, r);
		wr(12'h044, 8'h00); chk("unmapped write resp", 12'h2, s_axi_bresp);
		wr(12'h02C, 8'h00); chk("write resp", 12'h0, s_axi_bresp);
		for (int i = 0; i < 8; i++) begin
			v = (i < 2) ? 8'hFF : 8'($urandom);
			wr(i[0] ? 12'h078 : 12'h02C, v);
			rd(i[0] ? 12'h078 : 12'h02C, d, r);
			chk("readback", f_rb(i[0] ? 12'h078 : 12'h02C, v), d);
		end
		wr(12'h02C, 8'h0E);
		wr(12'h078, 8'h07);
		src <= 6'h3F;
		@(posedge core_clk);
		src <= 6'h03;
		repeat (3) @(posedge core_clk);
		src <= 6'h00;
		repeat (4) @(posedge core_clk);
		rd(12'h02C, d, r); chk("first flags", 12'h7E, d);
		rd(12'h078, d, r); chk("second flags", 12'h77, d);
		wr(12'h02C, 8'h7F);
		for (int i = 0; i < 6; i++) begin
			wait_take(40, got); chk("take", 12'h1, got);
			chk("vector", f_vec(i), irq_vector);
			rd(12'h02C, d, r); chk("global off", 12'h0, d[0]);
			if (i[0]) ret(2'h1);
			else wr(12'h02C, 8'h7F);
		end
		repeat (6) @(posedge core_clk);
		chk("depth", 12'h3, stack_index);
		call_push <= 1'h1;
		repeat (4) @(posedge core_clk);
		call_push <= 1'h0;
		@(posedge core_clk);
		chk("full", 12'h1, stack_full);
		src <= 6'h08;
		@(posedge core_clk);
		src <= 6'h00;
		wait_take(24, got); chk("held", 12'h0, got);
		rd(12'h078, d, r); chk("flag kept", 12'h17, d);
		rd(12'h100, d, r); chk("status", 12'h88, d);
		chk("wake", 12'h1, wake_up);
		ret(2'h2);
		wait_take(24, got); chk("take after pop", 12'h1, got);
		chk("vector after pop", 12'h010, irq_vector);
		conclude;
	end
endmodule // test_svic_ctrl
